// >>> rtl/usbrh_pkg.sv
// Shared constants and types of the root hub status block
package usbrh_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] HUB_OFS = 8'h50;
  localparam logic [7:0] PORT1_OFS = 8'h54;
  localparam logic [7:0] PORT2_OFS = 8'h58;
  localparam logic [7:0] CFG_OFS = 8'h5C;
  localparam int NUM_PORTS = 2;
  // Hub status bit positions
  localparam int HB_CLR_RWE = 31;
  localparam int HB_OCIC = 17;
  localparam int HB_GPON = 16;
  localparam int HB_RWE = 15;
  localparam int HB_OC = 1;
  localparam int HB_GPOFF = 0;
  // Port status bit positions
  localparam int PB_PRSC = 20;
  localparam int PB_OCIC = 19;
  localparam int PB_PSSC = 18;
  localparam int PB_PESC = 17;
  localparam int PB_CSC = 16;
  localparam int PB_LS = 9;
  localparam int PB_PWR = 8;
  localparam int PB_RST = 4;
  localparam int PB_OC = 3;
  localparam int PB_SUSP = 2;
  localparam int PB_EN = 1;
  localparam int PB_CONN = 0;
  // Configuration register fields
  localparam int CB_OC_DIS = 0;
  localparam int CB_OC_PERPORT = 1;
  localparam int CB_ALW_PWR = 2;
  localparam int CB_FIXED = 3;
  localparam logic [4:0] CFG_RESET = 5'h00;
  // Timing: port reset and resume signalling lengths
  localparam int CLK_HZ = 20000000;
  localparam int RESET_TIME_US = 10000;
  localparam int RESUME_TIME_US = 20000;
  localparam int RESET_CYCLES = RESET_TIME_US * (CLK_HZ / 1000000);
  localparam int RESUME_CYCLES = RESUME_TIME_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 19;
  // One Wishbone request as seen by the slave
  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } usbrh_wbreq_s;
endpackage

// >>> rtl/usbrh_root_hub.sv
// Root hub status and two-port status/control with a Wishbone slave
//
// What this block does
// - Hub status register at 50H, 32 bits
// - Hub bit31 write one clears wakeup enable
// - Hub bit17 sets on over-current change, W1C
// - Hub bit16 reads zero, write one powers all
// - Hub bit0 reads zero, write one unpowers all unless power is forced
// - Hub bit15 wakeup enable, write one sets
// - Hub bit1 follows over-current pin when valid
// - Bus reset state restores hub register defaults
// - Port registers at 54H and 58H, 32 bits
// - Port bit20 sets when reset signalling ends
// - Port bit19 sets on over-current change, W1C
// - Port bit18 sets when resume sequence completes
// - Port bit17 sets on hardware port disable
// - Port bit16 sets on connect change, W1C
// - Fixed device port resets bit16 to one
// - Bit9 low speed when attached; write powers off
// - Bit8 power state; write powers on; forced one
// - Bit4 resetting; write one starts port reset
// - Bit3 reads port over-current pin when valid
// - Bit3 write one starts selective resume
// - Bit2 suspended; write one suspends port
// - Bit1 enabled; write one enables port
// - Bit0 attached; write one disables port
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module usbrh_root_hub
  import usbrh_pkg::*;
#(
  parameter int RST_CYC = RESET_CYCLES,
  parameter int RES_CYC = RESUME_CYCLES
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Controller state
  input wire logic I_CONTROLLER_BUS_RESET_STATE,
  // Over-current pins
  input wire logic I_OVERCURRENT_PIN,
  input wire logic [1:0] I_PORT_OVERCURRENT_PIN,
  // Line state from the port transceivers
  input wire logic [1:0] I_DEVICE_ATTACHED,
  input wire logic [1:0] I_LOW_SPEED,
  // Port controls
  output logic [1:0] O_PORT_POWER,
  output logic [1:0] O_PORT_ENABLE,
  output logic [1:0] O_PORT_RESET,
  output logic [1:0] O_PORT_SUSPEND,
  output logic [1:0] O_PORT_RESUME,
  output logic O_REMOTE_WAKE
);

  // Write-one test on one bit, honouring its byte lane
  function automatic logic w1(input usbrh_wbreq_s r, input int pos);
    w1 = r.dat[pos] & r.sel[pos / 8];
  endfunction

  usbrh_wbreq_s req; // Request fields bundled
  logic ack_reg; // Bus answer
  logic [31:0] rdat_reg; // Read data
  logic [4:0] cfg_reg; // Configuration bits
  logic rwe_reg; // Remote wakeup enable
  logic ocic_reg; // Hub over-current change
  logic oc_prev_reg; // Last sampled over-current pin
  logic wake_reg; // Remote wakeup pulse
  // Per-port state; bit 0 is port 1, bit 1 is port 2
  logic [1:0] pwr_reg, en_reg, rst_reg, susp_reg, res_reg;
  // Per-port change flags, all cleared by writing one
  logic [1:0] prsc_reg, pocic_reg, pssc_reg, pesc_reg, csc_reg;
  // Last sampled pins, kept to spot changes
  logic [1:0] conn_prev_reg, poc_prev_reg;
  logic [CNT_W-1:0] cnt_reg [2]; // Reset/resume timers, one shared by both signallings
  logic clr; // Registers forced to defaults
  logic wr_fire; // Write takes effect this edge
  logic wr_hub, wr_cfg;
  logic [1:0] wr_port;
  logic [1:0] conn; // Attached as seen by software
  logic [1:0] csc_set, pesc_set;
  logic hub_oc_valid, port_oc_valid;
  logic [1:0] rst_done, res_done;

  // Bundle the request so the write-one helper sees lanes and data together
  assign req = '{adr: I_WB_ADR, we: I_WB_WE, sel: I_WB_SEL, dat: I_WB_DAT};
  // Bus reset state and power-on reset both force the status defaults
  assign clr = !I_RST_N || I_CONTROLLER_BUS_RESET_STATE;
  // Writes land on the edge where the master sees ack
  assign wr_fire = I_WB_CYC && I_WB_STB && I_WB_WE && ack_reg;
  assign wr_hub = wr_fire && (req.adr == HUB_OFS);
  assign wr_cfg = wr_fire && (req.adr == CFG_OFS);
  assign hub_oc_valid = !cfg_reg[CB_OC_DIS] && !cfg_reg[CB_OC_PERPORT];
  assign port_oc_valid = !cfg_reg[CB_OC_DIS] && cfg_reg[CB_OC_PERPORT];

  // Per-port strobes and events
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      wr_port[i] = wr_fire && (req.adr == PORT1_OFS + 8'(4 * i));
      // A fixed device always reads as attached
      conn[i] = I_DEVICE_ATTACHED[i] || cfg_reg[CB_FIXED + i];
      csc_set[i] = conn[i] != conn_prev_reg[i];
      // Losing the device or a valid per-port over-current drops enable without software
      pesc_set[i] = en_reg[i] && (!conn[i] || (port_oc_valid && I_PORT_OVERCURRENT_PIN[i]));
      rst_done[i] = rst_reg[i] && (cnt_reg[i] == CNT_W'(RST_CYC - 1));
      res_done[i] = res_reg[i] && (cnt_reg[i] == CNT_W'(RES_CYC - 1));
    end
  end

  // Bus slave: one wait state, ack for one cycle, unmapped reads zero
  // Read data is captured at the take edge; the master holds the address
  // until ack, so the value matches the request that ack answers
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= I_WB_CYC && I_WB_STB && !ack_reg;
      rdat_reg <= 32'h0000_0000;
      if (req.adr == HUB_OFS) begin
        rdat_reg[HB_OCIC] <= ocic_reg;
        rdat_reg[HB_RWE] <= rwe_reg;
        rdat_reg[HB_OC] <= hub_oc_valid && I_OVERCURRENT_PIN;
      end else if (req.adr == CFG_OFS) begin
        rdat_reg[4:0] <= cfg_reg;
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (req.adr == PORT1_OFS + 8'(4 * i)) begin
          rdat_reg[PB_PRSC] <= prsc_reg[i];
          rdat_reg[PB_OCIC] <= pocic_reg[i];
          rdat_reg[PB_PSSC] <= pssc_reg[i];
          rdat_reg[PB_PESC] <= pesc_reg[i];
          rdat_reg[PB_CSC] <= csc_reg[i];
          rdat_reg[PB_LS] <= conn[i] && I_LOW_SPEED[i];
          rdat_reg[PB_PWR] <= pwr_reg[i];
          rdat_reg[PB_RST] <= rst_reg[i];
          rdat_reg[PB_OC] <= port_oc_valid && I_PORT_OVERCURRENT_PIN[i];
          rdat_reg[PB_SUSP] <= susp_reg[i];
          rdat_reg[PB_EN] <= en_reg[i];
          rdat_reg[PB_CONN] <= conn[i];
        end
      end
    end
  end

  // Configuration survives the bus reset state; only power-on resets it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= req.dat[4:0];
    end
  end

  // Hub-wide flags
  always_ff @(posedge I_SYS_CLK) begin
    if (clr) begin
      rwe_reg <= 1'b0;
      ocic_reg <= 1'b0;
      // Keep tracking the pin so no false change follows the reset
      oc_prev_reg <= I_OVERCURRENT_PIN;
      wake_reg <= 1'b0;
    end else begin
      oc_prev_reg <= I_OVERCURRENT_PIN;
      // Setting beats clearing when both are written at once
      if (wr_hub && w1(req, HB_RWE)) begin
        rwe_reg <= 1'b1;
      end else if (wr_hub && w1(req, HB_CLR_RWE)) begin
        rwe_reg <= 1'b0;
      end
      // A change arriving with the clear still sets the flag
      ocic_reg <= (ocic_reg && !(wr_hub && w1(req, HB_OCIC)))
                  || (I_OVERCURRENT_PIN != oc_prev_reg);
      // Wake is a one-cycle pulse per connect change seen while enabled
      wake_reg <= rwe_reg && (|csc_set);
    end
  end

  // Port power, enable, reset, suspend and resume state
  always_ff @(posedge I_SYS_CLK) begin
    if (clr) begin
      pwr_reg <= 2'h0;
      en_reg <= 2'h0;
      rst_reg <= 2'h0;
      susp_reg <= 2'h0;
      res_reg <= 2'h0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        // Power: global and per-port commands, on wins over off
        if (cfg_reg[CB_ALW_PWR]) begin
          pwr_reg[i] <= 1'b1;
        end else if ((wr_hub && w1(req, HB_GPON)) || (wr_port[i] && w1(req, PB_PWR))) begin
          pwr_reg[i] <= 1'b1;
        end else if ((wr_hub && w1(req, HB_GPOFF)) || (wr_port[i] && w1(req, PB_LS))) begin
          pwr_reg[i] <= 1'b0;
        end
        // Enable: hardware events and reset completion
        if (rst_done[i]) begin
          en_reg[i] <= 1'b1;
        end else if (pesc_set[i]) begin
          en_reg[i] <= 1'b0;
        end else if (wr_port[i] && w1(req, PB_EN) && conn[i]) begin
          en_reg[i] <= 1'b1;
        end else if (wr_port[i] && w1(req, PB_CONN)) begin
          en_reg[i] <= 1'b0;
        end
        // Reset signalling only toward an attached device
        if (rst_done[i] || !conn[i]) begin
          rst_reg[i] <= 1'b0;
        end else if (wr_port[i] && w1(req, PB_RST) && !res_reg[i]) begin
          rst_reg[i] <= 1'b1;
        end
        // Suspend needs an enabled port; resume ends it
        if (res_done[i] || !en_reg[i]) begin
          susp_reg[i] <= 1'b0;
        end else if (wr_port[i] && w1(req, PB_SUSP) && !rst_reg[i]) begin
          susp_reg[i] <= 1'b1;
        end
        // Resume only from suspend; it ends on its own timer
        if (res_done[i] || !susp_reg[i]) begin
          res_reg[i] <= 1'b0;
        end else if (wr_port[i] && w1(req, PB_OC)) begin
          res_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Timers: restart whenever neither signalling is running
  // One counter per port serves both reset and resume; the state logic
  // refuses a reset while resuming, but a resume can still start during a reset
  always_ff @(posedge I_SYS_CLK) begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (clr || !(rst_reg[i] || res_reg[i]) || rst_done[i] || res_done[i]) begin
        cnt_reg[i] <= '0;
      end else begin
        cnt_reg[i] <= cnt_reg[i] + CNT_W'(1);
      end
    end
  end

  // Change flags: hardware set wins over a software clear
  always_ff @(posedge I_SYS_CLK) begin
    if (clr) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        csc_reg[i] <= cfg_reg[CB_FIXED + i];
        // Track the line through reset so a device present throughout
        // does not look like a fresh connect afterwards
        conn_prev_reg[i] <= conn[i];
      end
      prsc_reg <= 2'h0;
      pocic_reg <= 2'h0;
      pssc_reg <= 2'h0;
      pesc_reg <= 2'h0;
      poc_prev_reg <= I_PORT_OVERCURRENT_PIN;
    end else begin
      conn_prev_reg <= conn;
      poc_prev_reg <= I_PORT_OVERCURRENT_PIN;
      for (int i = 0; i < NUM_PORTS; i++) begin
        prsc_reg[i] <= (prsc_reg[i] && !(wr_port[i] && w1(req, PB_PRSC)))
                       || rst_done[i];
        pocic_reg[i] <= (pocic_reg[i] && !(wr_port[i] && w1(req, PB_OCIC)))
                        || (I_PORT_OVERCURRENT_PIN[i] != poc_prev_reg[i]);
        pssc_reg[i] <= (pssc_reg[i] && !(wr_port[i] && w1(req, PB_PSSC)))
                       || res_done[i];
        pesc_reg[i] <= (pesc_reg[i] && !(wr_port[i] && w1(req, PB_PESC)))
                       || pesc_set[i];
        csc_reg[i] <= (csc_reg[i] && !(wr_port[i] && w1(req, PB_CSC)))
                      || csc_set[i];
      end
    end
  end

  // Outputs straight from flip-flops
  // Assignments only rename registers, no logic in between
  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdat_reg;
  assign O_PORT_POWER = pwr_reg;
  assign O_PORT_ENABLE = en_reg;
  assign O_PORT_RESET = rst_reg;
  assign O_PORT_SUSPEND = susp_reg;
  assign O_PORT_RESUME = res_reg;
  assign O_REMOTE_WAKE = wake_reg;

  // Checks on the logic above, all in the one clock domain
  default clocking cb @(posedge I_SYS_CLK); endclocking
  // Nothing is checked while the status state is being forced to defaults
  default disable iff (clr);

  // Bus answer is a single-cycle pulse
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held more than one cycle");

  // Every new request is answered in the next cycle
  ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("request not answered next cycle");

  // Command and reserved hub bits never read back as one
  hub_zero_a: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR == HUB_OFS
    |-> O_WB_DAT[HB_GPON] == 1'b0 && O_WB_DAT[HB_GPOFF] == 1'b0
    && O_WB_DAT[31:18] == 14'h0000 && O_WB_DAT[14:2] == 13'h0000)
    else $error("hub reserved or command bit read nonzero");

  // Clearing the wakeup enable alone takes effect at once
  rwe_clear_a: assert property (wr_hub && w1(req, HB_CLR_RWE) && !w1(req, HB_RWE)
    |=> !rwe_reg)
    else $error("wakeup enable not cleared");

  // Setting the wakeup enable always wins
  rwe_set_a: assert property (wr_hub && w1(req, HB_RWE) |=> rwe_reg)
    else $error("wakeup enable not set");

  // A sampled change of the pin raises the flag on the next edge
  hub_ocic_a: assert property ($changed(I_OVERCURRENT_PIN) |=> ocic_reg)
    else $error("hub over-current change missed");

  // Global power on reaches both ports
  gpon_a: assert property (wr_hub && w1(req, HB_GPON) |=> pwr_reg == 2'h3)
    else $error("global power on failed");

  // Global power off reaches both ports unless power is forced
  gpoff_a: assert property (wr_hub && w1(req, HB_GPOFF) && !w1(req, HB_GPON)
    && !cfg_reg[CB_ALW_PWR] && wr_port == 2'h0 |=> pwr_reg == 2'h0)
    else $error("global power off failed");

  // End of reset signalling enables the port and flags it
  reset_end_a: assert property (rst_done[0]
    |=> !rst_reg[0] && prsc_reg[0] && en_reg[0])
    else $error("port reset completion wrong");

  // A reset request toward an attached, idle port starts the timer afresh
  reset_start_a: assert property (wr_port[0] && w1(req, PB_RST) && conn[0]
    && !res_reg[0] && !rst_reg[0] |=> rst_reg[0] && cnt_reg[0] == '0)
    else $error("port reset did not start");

  // End of resume leaves suspend and flags it
  resume_end_a: assert property (res_done[0] |=> !susp_reg[0] && pssc_reg[0])
    else $error("resume completion wrong");

  // Hardware loss of enable is flagged
  hw_disable_a: assert property (pesc_set[0] && !rst_done[0]
    |=> !en_reg[0] && pesc_reg[0])
    else $error("hardware disable not flagged");

  // A sampled connect change raises the flag on the next edge
  csc_set_a: assert property ($changed(I_DEVICE_ATTACHED[1]) && !cfg_reg[CB_FIXED + 1]
    |=> csc_reg[1])
    else $error("connect change missed");

  // Writing one clears the connect change flag when no new change arrives
  csc_clear_a: assert property (wr_port[0] && w1(req, PB_CSC) && !csc_set[0]
    |=> !csc_reg[0])
    else $error("connect change not cleared");

  // Software disable drops the enable flag
  sw_disable_a: assert property (wr_port[0] && w1(req, PB_CONN) && !w1(req, PB_EN)
    && !rst_done[0] |=> !en_reg[0])
    else $error("software disable not taken");

  // A suspend request on an enabled port that is not resetting is taken
  suspend_a: assert property (wr_port[0] && w1(req, PB_SUSP) && !rst_reg[0]
    && en_reg[0] && !res_done[0] |=> susp_reg[0])
    else $error("suspend request not taken");

  // Main scenarios
  reset_cov_c: cover property (rst_done[0]);
  resume_cov_c: cover property (res_done[0]);
  wake_cov_c: cover property (O_REMOTE_WAKE);
  disable_cov_c: cover property (pesc_set[0]);
  suspend_cov_c: cover property (O_PORT_SUSPEND[0]);

endmodule

// >>> test/testbench.sv
// Self-checking bench of the root hub status block
`timescale 1ns/1ns
module testbench;
  import usbrh_pkg::*;
  localparam int RST_N_CYC = 20; // Shortened port reset length
  localparam int RES_N_CYC = 30; // Shortened resume length
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lanes = 4'hF; // Byte lanes used by the next access
  logic [31:0] wdat = 32'h0;
  logic [31:0] odat;
  logic [31:0] rval;
  logic ack;
  logic bus_rst = 1'b0;
  logic oc = 1'b0;
  logic wake;
  logic [1:0] plug = 2'h0;
  logic [1:0] slow = 2'h0;
  logic [1:0] poc = 2'h0;
  logic [1:0] att, ls, ppoc, pwr, en, prst, susp, res;
  int err_total = 0;
  int n_compared = 0;
  int wakes = 0;
  always #25 clk = ~clk;
  usbrh_root_hub #(.RST_CYC(RST_N_CYC), .RES_CYC(RES_N_CYC)) usbrh_root_hub_i (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(odat), .O_WB_ACK(ack),
    .I_CONTROLLER_BUS_RESET_STATE(bus_rst), .I_OVERCURRENT_PIN(oc),
    .I_PORT_OVERCURRENT_PIN(ppoc), .I_DEVICE_ATTACHED(att), .I_LOW_SPEED(ls),
    .O_PORT_POWER(pwr), .O_PORT_ENABLE(en), .O_PORT_RESET(prst),
    .O_PORT_SUSPEND(susp), .O_PORT_RESUME(res), .O_REMOTE_WAKE(wake));
  usbrh_dev_model usbrh_dev_model_i (.i_clk(clk), .i_plug(plug), .i_slow(slow),
    .i_oc(poc), .o_attached(att), .o_low_speed(ls), .o_port_oc(ppoc));
  // Wake is a one-cycle pulse, so count every high cycle
  always @(posedge clk) begin
    if (wake === 1'b1) begin
      wakes <= wakes + 1;
    end
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle; waits for ack, bounded so a dead slave cannot hang us
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rval = odat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("wb_ack", {31'h0, ack}, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rval, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog, well above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("hub_def", HUB_OFS, 32'h0);
    rdc("p1_def", PORT1_OFS, 32'h0);
    rdc("p2_def", PORT2_OFS, 32'h0);
    wr(8'h60, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h60, 32'h0);
    wr(HUB_OFS, 32'h7FFC_7FFC);
    rdc("hub_rsvd", HUB_OFS, 32'h0);
    wr(PORT1_OFS, 32'hFFE0_FCE0);
    rdc("p1_rsvd", PORT1_OFS, 32'h0);
    tend("defaults");
    wr(HUB_OFS, 32'h0000_8000);
    rdc("rwe_set", HUB_OFS, 32'h0000_8000);
    plug <= 2'b10;
    idle(6);
    chk("wake_count", wakes, 32'h1);
    wr(HUB_OFS, 32'h8000_0000);
    rdc("rwe_clr", HUB_OFS, 32'h0);
    rdc("p2_conn", PORT2_OFS, 32'h0001_0001);
    wr(PORT2_OFS, 32'h0001_0000);
    rdc("p2_csc_clr", PORT2_OFS, 32'h1);
    tend("wake");
    wr(HUB_OFS, 32'h0001_0000);
    rdc("gpon", PORT1_OFS, 32'h100);
    rdc("hub_b16", HUB_OFS, 32'h0);
    wr(HUB_OFS, 32'h1);
    rdc("gpoff", PORT2_OFS, 32'h1);
    lanes = 4'hB;
    wr(HUB_OFS, 32'h0001_0000);
    lanes = 4'hF;
    rdc("lane_off", PORT2_OFS, 32'h1);
    oc <= 1'b1;
    idle(4);
    rdc("oc_set", HUB_OFS, 32'h0002_0002);
    wr(HUB_OFS, 32'h0002_0000);
    rdc("oci_clr", HUB_OFS, 32'h2);
    oc <= 1'b0;
    idle(4);
    rdc("oc_drop", HUB_OFS, 32'h0002_0000);
    wr(HUB_OFS, 32'h0002_0000);
    tend("hub");
    slow <= 2'b01;
    plug <= 2'b11;
    idle(4);
    rdc("p1_ls", PORT1_OFS, 32'h0001_0201);
    wr(PORT1_OFS, 32'h0001_0102);
    rdc("p1_en", PORT1_OFS, 32'h303);
    chk("en_pin", {30'h0, en}, 32'h1);
    chk("pwr_pin", {30'h0, pwr}, 32'h1);
    wr(PORT1_OFS, 32'h10);
    rdc("p1_rst", PORT1_OFS, 32'h313);
    chk("rst_pin", {30'h0, prst}, 32'h1);
    idle(RST_N_CYC + 4);
    rdc("p1_rst_done", PORT1_OFS, 32'h0010_0303);
    wr(PORT1_OFS, 32'h0010_0000);
    rdc("prsc_clr", PORT1_OFS, 32'h303);
    wr(PORT1_OFS, 32'h4);
    rdc("p1_susp", PORT1_OFS, 32'h307);
    chk("susp_pin", {30'h0, susp}, 32'h1);
    wr(PORT1_OFS, 32'h8);
    idle(2);
    chk("res_pin", {30'h0, res}, 32'h1);
    idle(RES_N_CYC + 2);
    rdc("p1_resumed", PORT1_OFS, 32'h0004_0303);
    chk("susp_end", {30'h0, susp}, 32'h0);
    chk("res_end", {30'h0, res}, 32'h0);
    wr(PORT1_OFS, 32'h0004_0000);
    wr(PORT1_OFS, 32'h1);
    rdc("p1_swdis", PORT1_OFS, 32'h301);
    wr(PORT1_OFS, 32'h2);
    plug <= 2'b10;
    idle(4);
    rdc("p1_hwdis", PORT1_OFS, 32'h0003_0100);
    wr(PORT1_OFS, 32'h0003_0200);
    rdc("p1_off", PORT1_OFS, 32'h0);
    tend("port");
    wr(CFG_OFS, 32'h2);
    poc <= 2'b10;
    idle(4);
    rdc("p2_oc", PORT2_OFS, 32'h0008_0009);
    wr(PORT2_OFS, 32'h0008_0000);
    rdc("p2_oci_clr", PORT2_OFS, 32'h9);
    poc <= 2'b00;
    idle(4);
    wr(PORT2_OFS, 32'h0008_0000);
    slow <= 2'b00;
    plug <= 2'b11;
    wr(CFG_OFS, 32'h8);
    wr(HUB_OFS, 32'h8000);
    bus_rst <= 1'b1;
    idle(3);
    bus_rst <= 1'b0;
    idle(2);
    rdc("hub_busrst", HUB_OFS, 32'h0);
    rdc("p1_fixed", PORT1_OFS, 32'h0001_0001);
    rdc("p2_busrst", PORT2_OFS, 32'h1);
    wr(CFG_OFS, 32'h4);
    rdc("p2_alw", PORT2_OFS, 32'h101);
    tend("config");
    test_done();
  end
endmodule

// >>> test/usbrh_dev_model.sv
// Behavioural model of the USB devices plugged into the two ports
`timescale 1ns/1ns
module usbrh_dev_model (
  // Clock and bench controls
  input wire logic i_clk,
  input wire logic [1:0] i_plug,
  input wire logic [1:0] i_slow,
  input wire logic [1:0] i_oc,
  // Lines seen by the hub
  output logic [1:0] o_attached,
  output logic [1:0] o_low_speed,
  output logic [1:0] o_port_oc
);
  // Junk level for a speed line with nothing plugged in
  logic [1:0] idle_reg = 2'h1;
  // An empty port has no speed level, so toggle rather than hold the last one
  always_ff @(posedge i_clk) begin
    idle_reg <= ~idle_reg;
  end
  // Presence is seen regardless of switched power, a simplification
  assign o_attached = i_plug;
  assign o_low_speed = (i_plug & i_slow) | (~i_plug & idle_reg);
  assign o_port_oc = i_oc;
endmodule
